// ===== shared/acd_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acd_dec_if;
    import acd_pkg::*;
    logic [7:0] cmd; // Command byte to decode
    acd_dec_s dec; // Decoded result
    modport ctrl (output cmd, input dec);
    modport dcd (input cmd, output dec);
endinterface
`default_nettype wire

// ===== shared/acd_params.svh
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH
// Command byte field positions
`define ACD_OPSEL_MSB 4
`define ACD_FIXED_BIT 5
`define ACD_SHORT_BIT 6
`define ACD_SVC_BIT 7
// Opcode values with the service bit clear
`define ACD_OP_NOP 7'h00
`define ACD_OP_SQUARE_ROOT 7'h01
`define ACD_OP_SINE 7'h02
`define ACD_OP_COSINE 7'h03
`define ACD_OP_TANGENT 7'h04
`define ACD_OP_ARCSINE 7'h05
`define ACD_OP_ARCCOSINE 7'h06
`define ACD_OP_ARCTANGENT 7'h07
`define ACD_OP_LOG_TEN 7'h08
`define ACD_OP_LOG_NAT 7'h09
`define ACD_OP_EXPONENT 7'h0A
`define ACD_OP_POWER 7'h0B
`define ACD_OP_FLOAT_ADD 7'h10
`define ACD_OP_FLOAT_SUB 7'h11
`define ACD_OP_FLOAT_MUL 7'h12
`define ACD_OP_FLOAT_DIV 7'h13
`define ACD_OP_FNEG 7'h15
`define ACD_OP_FPUSH 7'h17
`define ACD_OP_FPOP 7'h18
`define ACD_OP_FSWAP 7'h19
`define ACD_OP_PI 7'h1A
`define ACD_OP_L2F 7'h1C
`define ACD_OP_S2F 7'h1D
`define ACD_OP_F2L 7'h1E
`define ACD_OP_LADD 7'h2C
`define ACD_OP_LSUB 7'h2D
`define ACD_OP_LMULL 7'h2E
`define ACD_OP_LDIV 7'h2F
`define ACD_OP_LNEG 7'h34
`define ACD_OP_LMULH 7'h36
`define ACD_OP_LPUSH 7'h37
`define ACD_OP_LPOP 7'h38
`define ACD_OP_LSWAP 7'h39
// Flag mask bit positions: sign, zero, overflow, carry, error
`define ACD_FL_S 0
`define ACD_FL_Z 1
`define ACD_FL_O 2
`define ACD_FL_C 3
`define ACD_FL_E 4
// Default execution time in clocks for every command
`define ACD_EXEC_CYCLES 8'h08
`endif

// ===== shared/acd_pkg.sv
package acd_pkg;
    // Stack slot source after a command
    typedef enum logic [2:0] {
        ACD_SRC_A = 3'h0,
        ACD_SRC_B = 3'h1,
        ACD_SRC_C = 3'h2,
        ACD_SRC_D = 3'h3,
        ACD_SRC_R = 3'h4,
        ACD_SRC_U = 3'h5
    } acd_src_e;
    // Operation class
    typedef enum logic [2:0] {
        ACD_CL_NONE = 3'h0,
        ACD_CL_FLOAT = 3'h1,
        ACD_CL_FUNC = 3'h2,
        ACD_CL_CONV = 3'h3,
        ACD_CL_LONG = 3'h4,
        ACD_CL_STACK = 3'h5
    } acd_class_e;
    // Full decode result
    typedef struct packed {
        logic legal;
        acd_class_e op_class;
        logic fixed;
        logic short_int;
        logic service;
        logic [4:0] flag_mask;
        acd_src_e [3:0] stack_map;
    } acd_dec_s;
    // Controller states, one-hot
    typedef enum logic [1:0] {
        ACD_ST_IDLE = 2'b01,
        ACD_ST_BUSY = 2'b10
    } acd_state_e;
endpackage

// ===== testbench/acd_command_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acd_command_unit_chk (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Host strobes and acknowledges
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_BYTE,
    input wire logic DATA_RD,
    input wire logic DATA_WR,
    input wire logic SERVICE_ACK_IN_N,
    input wire logic DONE_ACK_IN_N,
    // Unit outputs
    input wire logic READY,
    input wire logic BUSY,
    input wire logic SERVICE_REQUEST_OUT,
    input wire logic DONE_N,
    input wire logic CMD_FIXED,
    input wire logic CMD_SHORT
);
    // ****************************************
    // Helpers
    // ****************************************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    logic take; // Command accepted this edge
    logic any_acc; // Any host access strobe
    assign take = CMD_WR && !BUSY;
    assign any_acc = CMD_WR || DATA_RD || DATA_WR;
    // ****************************************
    // Properties
    // ****************************************
    property p_exec_len;
        take |=> BUSY [*8] ##1 (!BUSY && !DONE_N);
    endproperty
    a_exec_len: assert property (p_exec_len)
        else $error("execution length or done wrong");
    property p_svc_end;
        take |-> ##9 (SERVICE_REQUEST_OUT == $past(CMD_BYTE[7], 9));
    endproperty
    a_svc_end: assert property (p_svc_end)
        else $error("service request at finish wrong");
    property p_svc_rise;
        $rose(SERVICE_REQUEST_OUT) |-> $fell(BUSY);
    endproperty
    a_svc_rise: assert property (p_svc_rise)
        else $error("service request rose outside finish");
    property p_svc_fall;
        $fell(SERVICE_REQUEST_OUT) && !$past(RST)
            |-> !$past(SERVICE_ACK_IN_N) || $fell(BUSY);
    endproperty
    a_svc_fall: assert property (p_svc_fall)
        else $error("service request dropped without cause");
    property p_svc_ack;
        !SERVICE_ACK_IN_N && !BUSY |=> !SERVICE_REQUEST_OUT;
    endproperty
    a_svc_ack: assert property (p_svc_ack)
        else $error("service acknowledge ignored");
    property p_ready;
        READY == !(BUSY && any_acc);
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready wrong");
    property p_done_clr;
        !BUSY && (!DONE_ACK_IN_N || any_acc) |=> DONE_N;
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("done not cleared");
    property p_done_hold;
        !DONE_N && DONE_ACK_IN_N && !any_acc |=> !DONE_N;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done dropped early");
    property p_fmt;
        take |=> CMD_FIXED == $past(CMD_BYTE[5])
            && CMD_SHORT == $past(CMD_BYTE[6]);
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("format bits wrong");
endmodule
`default_nettype wire

// ===== testbench/acd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
    // Clock and handshake from the unit
    input wire logic clk_sys,
    input wire logic ready,
    // Strobes and command byte
    output logic cmd_wr,
    output logic [7:0] cmd_byte,
    output logic data_rd,
    output logic data_wr,
    // Acknowledges, active low
    output logic svc_ack_n,
    output logic done_ack_n
);
    // Idle bus at time zero
    initial begin
        cmd_wr = 1'b0;
        cmd_byte = 8'h00;
        data_rd = 1'b0;
        data_wr = 1'b0;
        svc_ack_n = 1'b1;
        done_ack_n = 1'b1;
    end
    // Kind 0 command, 1 read, 2 write; held until ready seen before an edge
    task automatic access(input int kind, input logic [7:0] b);
        logic r;
        int n;
        @(negedge clk_sys);
        cmd_wr = (kind == 0);
        data_rd = (kind == 1);
        data_wr = (kind == 2);
        cmd_byte = b[5] ? b : (b & 8'hBF);
        r = 1'b0;
        n = 0;
        // Sample just before the edge so the unit's update cannot race
        while (!r && n < 100) begin
            #4;
            r = (ready === 1'b1);
            @(negedge clk_sys);
            n++;
        end
        cmd_wr = 1'b0;
        data_rd = 1'b0;
        data_wr = 1'b0;
        // Released byte must not keep looking valid
        cmd_byte = ~cmd_byte;
    endtask
    // One-cycle low acknowledge: 1 service, 0 done
    task automatic ack(input logic svc);
        @(negedge clk_sys);
        svc_ack_n = !svc;
        done_ack_n = svc;
        @(negedge clk_sys);
        svc_ack_n = 1'b1;
        done_ack_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== testbench/apu_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module apu_command_decoder_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_sys;
    logic rst;
    int cyc = 0; // Cycle count, also the hang limit
    int fail_count = 0;
    int check_count = 0;
    wire logic cmd_wr;
    wire logic [7:0] cmd_byte;
    wire logic data_rd;
    wire logic data_wr;
    wire logic svc_ack_n;
    wire logic done_ack_n;
    wire logic ready;
    wire logic busy;
    wire logic svc_req;
    wire logic done_n;
    wire logic cmd_legal;
    wire logic [2:0] cmd_class;
    wire logic cmd_fixed;
    wire logic cmd_short;
    wire logic [4:0] cmd_mask;
    wire logic [11:0] cmd_map;
    wire logic [15:0] dec_word; // Legal, class, flag mask
    wire logic [15:0] fmt_word; // Fixed, short, service
    assign dec_word = {7'h00, cmd_legal, cmd_class, cmd_mask};
    assign fmt_word = {13'h0000, cmd_fixed, cmd_short, svc_req};
    // Opcode, class, flag mask, new A B C D (4 result, 5 undefined)
    localparam logic [35:0] TBL [32] = '{
        36'h0_1213_4125, 36'h0_2203_4155, 36'h0_3203_4155, 36'h0_4213_4155,
        36'h0_5213_4555, 36'h0_6213_4555, 36'h0_7203_4155, 36'h0_8213_4155,
        36'h0_9213_4155, 36'h0_A213_4155, 36'h0_B213_4255, 36'h1_0113_4235,
        36'h1_1113_4235, 36'h1_2113_4235, 36'h1_3113_4235, 36'h1_5503_4123,
        36'h1_7503_0012, 36'h1_8503_1230, 36'h1_9503_1023, 36'h1_A503_4012,
        36'h1_C303_4125, 36'h1_D303_4125, 36'h1_E307_4125, 36'h2_C41B_4230,
        36'h2_D40F_4230, 36'h2_E407_4235, 36'h2_F413_4235, 36'h3_4507_4123,
        36'h3_6407_4235, 36'h3_7503_0012, 36'h3_8503_1230, 36'h3_9503_1023
    };
    acd_command_unit u_acd_command_unit (
        .CLK_SYS(clk_sys), .RST(rst), .CMD_WR(cmd_wr), .CMD_BYTE(cmd_byte),
        .DATA_RD(data_rd), .DATA_WR(data_wr), .SERVICE_ACK_IN_N(svc_ack_n),
        .DONE_ACK_IN_N(done_ack_n), .READY(ready), .BUSY(busy),
        .SERVICE_REQUEST_OUT(svc_req), .DONE_N(done_n),
        .CMD_LEGAL(cmd_legal), .CMD_CLASS(cmd_class), .CMD_FIXED(cmd_fixed),
        .CMD_SHORT(cmd_short), .CMD_FLAG_MASK(cmd_mask),
        .CMD_STACK_MAP(cmd_map)
    );
    acd_host_model u_acd_host_model (
        .clk_sys(clk_sys), .ready(ready), .cmd_wr(cmd_wr),
        .cmd_byte(cmd_byte), .data_rd(data_rd), .data_wr(data_wr),
        .svc_ack_n(svc_ack_n), .done_ack_n(done_ack_n)
    );
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard; a normal run needs well under this
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    // Slot letters to the packed three-bit map, new A lowest
    function automatic logic [11:0] to_map(input logic [15:0] s);
        return {s[2:0], s[6:4], s[10:8], s[14:12]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done_n !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        int k;
        int t0;
        logic [35:0] e;
        rst = 1'b1;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        check({8'h00, ready, busy, svc_req, done_n, dec_word[8:5]}, 16'h0090);
        // Every opcode but NOP, service bit alternating so each clears the last
        for (k = 0; k < 32; k++) begin
            e = TBL[k];
            u_acd_host_model.access(0, {k[0], e[34:28]});
            wait_done();
            check(dec_word, {8'h01, e[26:24], e[20:16]});
            check({4'h0, cmd_map}, {4'h0, to_map(e[15:0])});
            check(fmt_word, {13'h0000, e[33], 1'b0, k[0]});
        end
        // Opcode outside the table, short fixed format
        u_acd_host_model.access(0, 8'h6C);
        wait_done();
        check(dec_word & 16'h011F, 16'h0000);
        check(fmt_word, 16'h0006);
        // Command, read and write while busy stall until execution ends
        for (k = 0; k < 3; k++) begin
            u_acd_host_model.access(0, 8'h10);
            t0 = cyc;
            u_acd_host_model.access(k, 8'h36);
            check(16'(cyc - t0), 16'h0009);
            if (k == 0) begin
                wait_done();
                check(dec_word, 16'h0187);
            end else begin
                check({15'h0000, done_n}, 16'h0001);
            end
        end
        // Request and done both hold until their own acknowledge
        u_acd_host_model.access(0, 8'h90);
        wait_done();
        repeat (3) @(negedge clk_sys);
        check({15'h0000, svc_req}, 16'h0001);
        u_acd_host_model.ack(1'b1);
        check({14'h0000, svc_req, done_n}, 16'h0000);
        u_acd_host_model.ack(1'b0);
        check({15'h0000, done_n}, 16'h0001);
        summarize();
    end
endmodule
bind acd_command_unit acd_command_unit_chk u_acd_command_unit_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .CMD_WR(CMD_WR), .CMD_BYTE(CMD_BYTE),
    .DATA_RD(DATA_RD), .DATA_WR(DATA_WR),
    .SERVICE_ACK_IN_N(SERVICE_ACK_IN_N), .DONE_ACK_IN_N(DONE_ACK_IN_N),
    .READY(READY), .BUSY(BUSY), .SERVICE_REQUEST_OUT(SERVICE_REQUEST_OUT),
    .DONE_N(DONE_N), .CMD_FIXED(CMD_FIXED), .CMD_SHORT(CMD_SHORT)
);
`default_nettype wire

// ===== verilog/acd_command_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_params.svh"
// Summary of operation
// - Each command is one byte, fully decoded
// - Bits zero to six select the operation
// - Bit five set means fixed point
// - Bit six picks 16 or 32 bit
// - Bit seven set raises service request at end
// - Request held until acknowledge or clean command
// - Bit seven clear keeps service request low
// - Float add, subtract, multiply, divide decoded
// - Single-operand float functions and power decoded
// - Error flag reported by most functions; sine, cosine, arctangent omit it
// - Integer to float conversions decoded
// - Float to long integer conversion decoded
// - Long add, subtract, divide decoded
// - Long multiply low and high decoded
// - Service bit never changes selected operation
// - Done output low at end, cleared on access
// - Ready low for accesses while executing
module acd_command_unit
    import acd_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Host strobes, held until READY is seen high
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_BYTE,
    input wire logic DATA_RD,
    input wire logic DATA_WR,
    // Acknowledge inputs, active low
    input wire logic SERVICE_ACK_IN_N,
    input wire logic DONE_ACK_IN_N,
    // Handshake and status outputs
    output logic READY,
    output logic BUSY,
    output logic SERVICE_REQUEST_OUT,
    output logic DONE_N,
    // Decoded command of the executing operation
    output logic CMD_LEGAL,
    output logic [2:0] CMD_CLASS,
    output logic CMD_FIXED,
    output logic CMD_SHORT,
    output logic [4:0] CMD_FLAG_MASK,
    output logic [11:0] CMD_STACK_MAP
);
    acd_dec_if dif (); // Link to the decoder

    // ********************************************
    // State
    // ********************************************
    acd_state_e state; // Controller state
    acd_state_e next_state;
    logic [7:0] cycles; // Execution countdown
    logic [7:0] next_cycles;
    logic svc_pend; // Bit seven of executing command
    logic next_svc_pend;
    logic svc_req; // Service request flop
    logic next_svc_req;
    logic done_n; // Completion output flop
    logic next_done_n;
    acd_dec_s dec_q; // Latched decode
    acd_dec_s next_dec_q;
    logic finish; // Last busy cycle
    logic access; // Any host access this cycle

    acd_decode u_dec (
        .bus(dif)
    );

    assign dif.cmd = CMD_BYTE;
    assign finish = (state == ACD_ST_BUSY) && (cycles == 8'h01);
    assign access = CMD_WR | DATA_RD | DATA_WR;

    // ********************************************
    // Next-state logic
    // ********************************************
    always_comb begin
        next_state = state;
        next_cycles = cycles;
        next_svc_pend = svc_pend;
        next_svc_req = svc_req;
        next_done_n = done_n;
        next_dec_q = dec_q;
        unique case (state)
            ACD_ST_IDLE: begin
                // Accept a command only while idle
                if (CMD_WR) begin
                    next_state = ACD_ST_BUSY;
                    next_cycles = `ACD_EXEC_CYCLES;
                    next_svc_pend = CMD_BYTE[`ACD_SVC_BIT];
                    next_dec_q = dif.dec;
                end
            end
            ACD_ST_BUSY: begin
                // Count down; host accesses stall meanwhile
                next_cycles = cycles - 8'h01;
                if (finish) begin
                    next_state = ACD_ST_IDLE;
                end
            end
            default: begin
                next_state = ACD_ST_IDLE;
            end
        endcase
        // Clearing: acknowledge low drops the request
        if (!SERVICE_ACK_IN_N) begin
            next_svc_req = 1'b0;
        end
        // Completion decides from its own command's bit seven
        if (finish) begin
            next_svc_req = svc_pend;
        end
        // Done clears on ack or access; set on finish wins
        if (!DONE_ACK_IN_N || (access && state == ACD_ST_IDLE)) begin
            next_done_n = 1'b1;
        end
        if (finish) begin
            next_done_n = 1'b0;
        end
    end

    // ********************************************
    // Registers
    // ********************************************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= ACD_ST_IDLE;
            cycles <= 8'h00;
            svc_pend <= 1'b0;
            svc_req <= 1'b0;
            done_n <= 1'b1;
            dec_q <= '0;
        end else begin
            state <= next_state;
            cycles <= next_cycles;
            svc_pend <= next_svc_pend;
            svc_req <= next_svc_req;
            done_n <= next_done_n;
            dec_q <= next_dec_q;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    // Ready drops only while an access waits on execution
    assign READY = !(access && state == ACD_ST_BUSY);
    assign BUSY = (state == ACD_ST_BUSY);
    assign SERVICE_REQUEST_OUT = svc_req;
    assign DONE_N = done_n;
    assign CMD_LEGAL = dec_q.legal;
    assign CMD_CLASS = dec_q.op_class;
    assign CMD_FIXED = dec_q.fixed;
    assign CMD_SHORT = dec_q.short_int;
    assign CMD_FLAG_MASK = dec_q.flag_mask;
    assign CMD_STACK_MAP = dec_q.stack_map;
endmodule
`default_nettype wire

// ===== verilog/acd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_params.svh"
module acd_decode
    import acd_pkg::*;
(
    // Command in, decode out
    acd_dec_if.dcd bus
);
    logic [6:0] op; // Opcode with service bit stripped
    logic [4:0] s_z; // Sign and zero mask
    logic [4:0] s_z_e; // Sign, zero, error
    logic [4:0] s_z_o; // Sign, zero, overflow

    assign s_z = 5'h03;
    assign s_z_e = 5'h13;
    assign s_z_o = 5'h07;

    // ********************************************
    // Opcode table
    // ********************************************
    always_comb begin
        op = bus.cmd[`ACD_SHORT_BIT:0];
        bus.dec = '0;
        bus.dec.fixed = bus.cmd[`ACD_FIXED_BIT];
        bus.dec.short_int = bus.cmd[`ACD_SHORT_BIT];
        bus.dec.service = bus.cmd[`ACD_SVC_BIT];
        bus.dec.legal = 1'b1;
        bus.dec.stack_map = {ACD_SRC_D, ACD_SRC_C, ACD_SRC_B, ACD_SRC_A};
        // Whole operation chosen from one byte; bits 0-6 select
        unique case (op)
            `ACD_OP_NOP: begin
                bus.dec.op_class = ACD_CL_NONE;
            end
            `ACD_OP_SINE, `ACD_OP_COSINE, `ACD_OP_ARCTANGENT: begin
                bus.dec.op_class = ACD_CL_FUNC;
                bus.dec.flag_mask = s_z;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_U, ACD_SRC_B,
                    ACD_SRC_R};
            end
            `ACD_OP_SQUARE_ROOT: begin
                bus.dec.op_class = ACD_CL_FUNC;
                bus.dec.flag_mask = s_z_e;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_C, ACD_SRC_B,
                    ACD_SRC_R};
            end
            `ACD_OP_ARCSINE, `ACD_OP_ARCCOSINE: begin
                bus.dec.op_class = ACD_CL_FUNC;
                bus.dec.flag_mask = s_z_e;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_U, ACD_SRC_U,
                    ACD_SRC_R};
            end
            `ACD_OP_TANGENT, `ACD_OP_LOG_TEN, `ACD_OP_LOG_NAT,
            `ACD_OP_EXPONENT: begin
                bus.dec.op_class = ACD_CL_FUNC;
                bus.dec.flag_mask = s_z_e;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_U, ACD_SRC_B,
                    ACD_SRC_R};
            end
            `ACD_OP_POWER: begin
                bus.dec.op_class = ACD_CL_FUNC;
                bus.dec.flag_mask = s_z_e;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_U, ACD_SRC_C,
                    ACD_SRC_R};
            end
            `ACD_OP_FLOAT_ADD, `ACD_OP_FLOAT_SUB, `ACD_OP_FLOAT_MUL,
            `ACD_OP_FLOAT_DIV: begin
                bus.dec.op_class = ACD_CL_FLOAT;
                bus.dec.flag_mask = s_z_e;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_D, ACD_SRC_C,
                    ACD_SRC_R};
            end
            `ACD_OP_L2F, `ACD_OP_S2F: begin
                bus.dec.op_class = ACD_CL_CONV;
                bus.dec.flag_mask = s_z;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_C, ACD_SRC_B,
                    ACD_SRC_R};
            end
            `ACD_OP_F2L: begin
                bus.dec.op_class = ACD_CL_CONV;
                bus.dec.flag_mask = s_z_o;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_C, ACD_SRC_B,
                    ACD_SRC_R};
            end
            `ACD_OP_LADD: begin
                bus.dec.op_class = ACD_CL_LONG;
                bus.dec.flag_mask = 5'h1B;
                bus.dec.stack_map = {ACD_SRC_A, ACD_SRC_D, ACD_SRC_C,
                    ACD_SRC_R};
            end
            `ACD_OP_LSUB: begin
                bus.dec.op_class = ACD_CL_LONG;
                bus.dec.flag_mask = 5'h0F;
                bus.dec.stack_map = {ACD_SRC_A, ACD_SRC_D, ACD_SRC_C,
                    ACD_SRC_R};
            end
            `ACD_OP_LDIV: begin
                bus.dec.op_class = ACD_CL_LONG;
                bus.dec.flag_mask = s_z_e;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_D, ACD_SRC_C,
                    ACD_SRC_R};
            end
            `ACD_OP_LMULL, `ACD_OP_LMULH: begin
                bus.dec.op_class = ACD_CL_LONG;
                bus.dec.flag_mask = s_z_o;
                bus.dec.stack_map = {ACD_SRC_U, ACD_SRC_D, ACD_SRC_C,
                    ACD_SRC_R};
            end
            `ACD_OP_FNEG, `ACD_OP_LNEG: begin
                bus.dec.op_class = ACD_CL_STACK;
                bus.dec.flag_mask = (op == `ACD_OP_LNEG) ? s_z_o : s_z;
                bus.dec.stack_map = {ACD_SRC_D, ACD_SRC_C, ACD_SRC_B,
                    ACD_SRC_R};
            end
            `ACD_OP_FPUSH, `ACD_OP_LPUSH: begin
                bus.dec.op_class = ACD_CL_STACK;
                bus.dec.flag_mask = s_z;
                bus.dec.stack_map = {ACD_SRC_C, ACD_SRC_B, ACD_SRC_A,
                    ACD_SRC_A};
            end
            `ACD_OP_FPOP, `ACD_OP_LPOP: begin
                bus.dec.op_class = ACD_CL_STACK;
                bus.dec.flag_mask = s_z;
                bus.dec.stack_map = {ACD_SRC_A, ACD_SRC_D, ACD_SRC_C,
                    ACD_SRC_B};
            end
            `ACD_OP_FSWAP, `ACD_OP_LSWAP: begin
                bus.dec.op_class = ACD_CL_STACK;
                bus.dec.flag_mask = s_z;
                bus.dec.stack_map = {ACD_SRC_D, ACD_SRC_C, ACD_SRC_A,
                    ACD_SRC_B};
            end
            `ACD_OP_PI: begin
                bus.dec.op_class = ACD_CL_STACK;
                bus.dec.flag_mask = s_z;
                bus.dec.stack_map = {ACD_SRC_C, ACD_SRC_B, ACD_SRC_A,
                    ACD_SRC_R};
            end
            // Anything else has no defined result; flagged illegal
            default: begin
                bus.dec.legal = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire
